/* include/pss_pkg.sv */
// Constants and types for the PHY soft-strap default loader.
package pss_pkg;

  typedef enum logic {
    PSS_ST_LOAD,
    PSS_ST_RUN
  } pss_state_e;

  // Field positions inside the grouped register vectors, and the mode field width.
  localparam int EEE_EN_POS   = 2;
  localparam int EEE_CAP_POS  = 1;
  localparam int EEE_ADV_POS  = 0;
  localparam int BC_AN_POS    = 2;
  localparam int BC_SPEED_POS = 1;
  localparam int BC_DUP_POS   = 0;
  localparam int ADV_10FD_POS = 1;
  localparam int ADV_10HD_POS = 0;
  localparam int CAP_AUTO_POS = 2;
  localparam int CAP_MAN_POS  = 1;
  localparam int CAP_FIB_POS  = 0;
  localparam int MODE_W       = 3;

  // Values held while reset is asserted, before the straps are loaded.
  localparam logic [2:0]        EEE_RST   = 3'h0;
  localparam logic [2:0]        BASIC_RST = 3'h0;
  localparam logic [1:0]        ADV_RST   = 2'h0;
  localparam logic [MODE_W-1:0] MODE_RST  = 3'h0;
  localparam logic [2:0]        CAP_RST   = 3'h0;
  localparam logic              XSTATE_RST = 1'h0;

  // Documented strap defaults.
  localparam logic AUTO_XOVER_STRAP_DEF = 1'h1;
  localparam logic MANUAL_XOVER_STRAP_DEF = 1'h0;

  // Values used in place of the straps while a PHY runs in fibre mode.
  localparam logic       FIB_EEE        = 1'h0;
  localparam logic       FIB_AN         = 1'h0;
  localparam logic       FIB_SPEED      = 1'h1;
  localparam logic [1:0] FIB_ADV        = 2'h0;
  localparam logic       FIB_XOVER_AUTO = 1'h0;
  localparam logic       FIB_XOVER_MDIX = 1'h0;

endpackage

/* hw/pss_field_reg.sv */
// Register group with a load-once default and a software write port.
`timescale 1ns/1ps
`default_nettype none
module pss_field_reg #(
  parameter int              W       = 1,
  parameter logic [W-1:0]    RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         srst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         wr,
  input  wire logic [W-1:0] wr_val,
  output logic      [W-1:0] q
);

  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  always_comb begin
    q_next = q_reg;
    if (load) begin
      q_next = load_val;
    end else if (wr) begin
      q_next = wr_val;
    end
  end

  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      q_reg <= RST_VAL;
    end else begin
      q_reg <= q_next;
    end
  end

  assign q = q_reg;

endmodule
`default_nettype wire

/* hw/pss_top.sv */
// Soft-strap loader that derives PHY A and PHY B register defaults.
`timescale 1ns/1ps
`default_nettype none
module pss_top
  import pss_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              port1_energy_saving_strap,
  input  wire logic              auto_xover_strap,
  input  wire logic              manual_xover_strap,
  input  wire logic              negotiation_strap,
  input  wire logic              speed_strap,
  input  wire logic              duplex_strap,
  input  wire logic              fibre_mode_a,
  input  wire logic              fibre_mode_b,
  input  wire logic              crossover_control_field,
  input  wire logic              sw_xover_auto,
  input  wire logic              sw_xover_mdix,
  input  wire logic              sw_eee_wr,
  input  wire logic [2:0]        sw_eee_data,
  input  wire logic              sw_basic_wr,
  input  wire logic [2:0]        sw_basic_data,
  input  wire logic              sw_advert_wr,
  input  wire logic [1:0]        sw_advert_data,
  input  wire logic              sw_mode_wr,
  input  wire logic [MODE_W-1:0] sw_mode_data,
  output logic                   phy_energy_saving_enable_bit,
  output logic                   eee_cap_100tx,
  output logic                   eee_adv_100tx,
  output logic                   auto_crossover_strap_state_bit,
  output logic                   negotiation_enable_bit,
  output logic                   speed_select_low_bit,
  output logic                   duplex_mode_bit,
  output logic                   advert_10fd,
  output logic                   advert_10hd,
  output logic      [MODE_W-1:0] operating_mode,
  output logic                   xover_auto_en,
  output logic                   xover_mdix,
  output logic                   defaults_loaded
);

  // Reset is released through two flops so that every later flop sees a
  // clean, clock-aligned deassertion.
  logic rst_meta_reg;
  logic srst_n;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'b0;
      srst_n       <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      srst_n       <= rst_meta_reg;
    end
  end

  pss_state_e state_reg;
  pss_state_e state_next;
  logic       loaded_reg;
  logic       loaded_next;
  logic       load;
  logic       run;

  always_comb begin
    state_next  = state_reg;
    loaded_next = loaded_reg;
    case (state_reg)
      PSS_ST_LOAD: begin
        state_next  = PSS_ST_RUN;
        loaded_next = 1'b1;
      end
      PSS_ST_RUN: begin
        state_next = PSS_ST_RUN;
      end
      default: begin
        state_next = PSS_ST_LOAD;
      end
    endcase
  end

  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      state_reg  <= PSS_ST_LOAD;
      loaded_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      loaded_reg <= loaded_next;
    end
  end

  // Straps are sampled only in the single load cycle; writes that arrive
  // before the block runs are dropped rather than racing the load.
  assign load = (state_reg == PSS_ST_LOAD);
  assign run  = (state_reg == PSS_ST_RUN);

  logic [2:0]        eee_dflt;
  logic [2:0]        basic_dflt;
  logic [1:0]        adv_dflt;
  logic [MODE_W-1:0] mode_dflt;
  logic [2:0]        cap_dflt;
  logic              xstate_dflt;
  logic              eff_an;
  logic              eff_speed;

  always_comb begin
    eee_dflt = {3{fibre_mode_a ? FIB_EEE : port1_energy_saving_strap}};
    xstate_dflt = fibre_mode_b ? AUTO_XOVER_STRAP_DEF : auto_xover_strap;
    cap_dflt = '0;
    cap_dflt[CAP_AUTO_POS] = fibre_mode_b ? FIB_XOVER_AUTO : auto_xover_strap;
    cap_dflt[CAP_MAN_POS]  = fibre_mode_b ? MANUAL_XOVER_STRAP_DEF
                                          : manual_xover_strap;
    cap_dflt[CAP_FIB_POS]  = fibre_mode_b;
    eff_an    = fibre_mode_b ? FIB_AN : negotiation_strap;
    eff_speed = fibre_mode_b ? FIB_SPEED : speed_strap;
    // With negotiation on, forced speed and duplex read as the best case.
    basic_dflt = '0;
    basic_dflt[BC_AN_POS]    = eff_an;
    basic_dflt[BC_SPEED_POS] = eff_an | eff_speed;
    basic_dflt[BC_DUP_POS]   = eff_an | duplex_strap;
    adv_dflt = '0;
    if (fibre_mode_b) begin
      adv_dflt = FIB_ADV;
    end else begin
      adv_dflt[ADV_10HD_POS] = eff_an | ~eff_speed;
      adv_dflt[ADV_10FD_POS] = (eff_an | ~eff_speed) & duplex_strap;
    end
    mode_dflt = {eff_an, eff_speed, duplex_strap};
  end

  logic [2:0] eee_q;
  logic [2:0] basic_q;
  logic [1:0] adv_q;
  logic [2:0] cap_q;
  logic [0:0] xstate_q;

  pss_field_reg #(.W(3), .RST_VAL(EEE_RST)) u_eee (
    .clk      (clk),
    .srst_n   (srst_n),
    .load     (load),
    .load_val (eee_dflt),
    .wr       (run & sw_eee_wr),
    .wr_val   (sw_eee_data),
    .q        (eee_q)
  );

  pss_field_reg #(.W(3), .RST_VAL(BASIC_RST)) u_basic (
    .clk      (clk),
    .srst_n   (srst_n),
    .load     (load),
    .load_val (basic_dflt),
    .wr       (run & sw_basic_wr),
    .wr_val   (sw_basic_data),
    .q        (basic_q)
  );

  pss_field_reg #(.W(2), .RST_VAL(ADV_RST)) u_adv (
    .clk      (clk),
    .srst_n   (srst_n),
    .load     (load),
    .load_val (adv_dflt),
    .wr       (run & sw_advert_wr),
    .wr_val   (sw_advert_data),
    .q        (adv_q)
  );

  pss_field_reg #(.W(MODE_W), .RST_VAL(MODE_RST)) u_mode (
    .clk      (clk),
    .srst_n   (srst_n),
    .load     (load),
    .load_val (mode_dflt),
    .wr       (run & sw_mode_wr),
    .wr_val   (sw_mode_data),
    .q        (operating_mode)
  );

  // Captured strap copies, kept for the run-time crossover choice.
  pss_field_reg #(.W(3), .RST_VAL(CAP_RST)) u_cap (
    .clk      (clk),
    .srst_n   (srst_n),
    .load     (load),
    .load_val (cap_dflt),
    .wr       (1'b0),
    .wr_val   (3'h0),
    .q        (cap_q)
  );

  // The strap-state bit is read-only to software.
  pss_field_reg #(.W(1), .RST_VAL(XSTATE_RST)) u_xstate (
    .clk      (clk),
    .srst_n   (srst_n),
    .load     (load),
    .load_val (xstate_dflt),
    .wr       (1'b0),
    .wr_val   (1'b0),
    .q        (xstate_q)
  );

  assign phy_energy_saving_enable_bit   = eee_q[EEE_EN_POS];
  assign eee_cap_100tx                  = eee_q[EEE_CAP_POS];
  assign eee_adv_100tx                  = eee_q[EEE_ADV_POS];
  assign negotiation_enable_bit         = basic_q[BC_AN_POS];
  assign speed_select_low_bit           = basic_q[BC_SPEED_POS];
  assign duplex_mode_bit                = basic_q[BC_DUP_POS];
  assign advert_10fd                    = adv_q[ADV_10FD_POS];
  assign advert_10hd                    = adv_q[ADV_10HD_POS];
  assign auto_crossover_strap_state_bit = xstate_q[0];
  assign defaults_loaded                = loaded_reg;

  logic xauto_reg;
  logic xauto_next;
  logic xmdix_reg;
  logic xmdix_next;

  // Fibre has no twisted pair, so crossover is pinned to MDI there.
  always_comb begin
    xauto_next = 1'b0;
    xmdix_next = 1'b0;
    if (!run || cap_q[CAP_FIB_POS]) begin
      xauto_next = FIB_XOVER_AUTO;
      xmdix_next = FIB_XOVER_MDIX;
    end else if (crossover_control_field) begin
      xauto_next = cap_q[CAP_AUTO_POS];
      xmdix_next = ~cap_q[CAP_AUTO_POS] & cap_q[CAP_MAN_POS];
    end else begin
      xauto_next = sw_xover_auto;
      xmdix_next = ~sw_xover_auto & sw_xover_mdix;
    end
  end

  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      xauto_reg <= 1'b0;
      xmdix_reg <= 1'b0;
    end else begin
      xauto_reg <= xauto_next;
      xmdix_reg <= xmdix_next;
    end
  end

  assign xover_auto_en = xauto_reg;
  assign xover_mdix    = xmdix_reg;

  property p_eee_load;
    @(posedge clk) disable iff (!srst_n)
    load |=> eee_q == {3{$past(fibre_mode_a) ? FIB_EEE
                                             : $past(port1_energy_saving_strap)}};
  endproperty
  a_eee_load: assert property (p_eee_load) else $error("eee default wrong");

  property p_fibre_b;
    @(posedge clk) disable iff (!srst_n)
    (load && fibre_mode_b) |=> !negotiation_enable_bit && adv_q == FIB_ADV
                              && auto_crossover_strap_state_bit;
  endproperty
  a_fibre_b: assert property (p_fibre_b) else $error("fibre straps leaked");

  property p_xstate;
    @(posedge clk) disable iff (!srst_n)
    (load && !fibre_mode_b) |=> auto_crossover_strap_state_bit
                                == $past(auto_xover_strap);
  endproperty
  a_xstate: assert property (p_xstate) else $error("strap state wrong");

  property p_xover_strap;
    @(posedge clk) disable iff (!srst_n)
    (run && crossover_control_field && !cap_q[CAP_FIB_POS])
      |=> xover_auto_en == $past(cap_q[CAP_AUTO_POS]);
  endproperty
  a_xover_strap: assert property (p_xover_strap) else $error("auto xover wrong");

  property p_mdix;
    @(posedge clk) disable iff (!srst_n)
    (run && crossover_control_field && !cap_q[CAP_FIB_POS]
     && !cap_q[CAP_AUTO_POS]) |=> xover_mdix == $past(cap_q[CAP_MAN_POS]);
  endproperty
  a_mdix: assert property (p_mdix) else $error("manual mdix wrong");

  property p_an;
    @(posedge clk) disable iff (!srst_n)
    (load && !fibre_mode_b) |=> negotiation_enable_bit
                                == $past(negotiation_strap);
  endproperty
  a_an: assert property (p_an) else $error("negotiation default wrong");

  property p_an_shape;
    @(posedge clk) disable iff (!srst_n)
    (load && !fibre_mode_b && negotiation_strap) |=> speed_select_low_bit
      && duplex_mode_bit && advert_10hd && operating_mode[2];
  endproperty
  a_an_shape: assert property (p_an_shape) else $error("an shaping wrong");

  property p_speed;
    @(posedge clk) disable iff (!srst_n)
    (load && !fibre_mode_b && !negotiation_strap) |=>
      speed_select_low_bit == $past(speed_strap)
      && advert_10hd == !$past(speed_strap)
      && operating_mode[1] == $past(speed_strap);
  endproperty
  a_speed: assert property (p_speed) else $error("speed shaping wrong");

  property p_duplex;
    @(posedge clk) disable iff (!srst_n)
    (load && !negotiation_strap) |=> duplex_mode_bit == $past(duplex_strap)
      && operating_mode[0] == $past(duplex_strap)
      && ($past(duplex_strap) || !advert_10fd);
  endproperty
  a_duplex: assert property (p_duplex) else $error("duplex shaping wrong");

  property p_sw_wins;
    @(posedge clk) disable iff (!srst_n)
    (run && sw_basic_wr) |=> basic_q == $past(sw_basic_data) ##1
      ($past(sw_basic_wr) || $stable(basic_q) || !run);
  endproperty
  a_sw_wins: assert property (p_sw_wins) else $error("write not kept");

  property p_load_once;
    @(posedge clk) disable iff (!srst_n)
    run |=> run && !load;
  endproperty
  a_load_once: assert property (p_load_once) else $error("second load");

  c_load_fibre: cover property (@(posedge clk) disable iff (!srst_n)
    load && fibre_mode_b);
  c_mdix: cover property (@(posedge clk) disable iff (!srst_n)
    run && xover_mdix);
  c_sw_write: cover property (@(posedge clk) disable iff (!srst_n)
    run && sw_basic_wr ##1 sw_mode_wr);
  c_an_off: cover property (@(posedge clk) disable iff (!srst_n)
    load && !negotiation_strap && !speed_strap);

endmodule
`default_nettype wire

/* testbench/pss_strap_src.sv */
// Strap source model: configuration levels that are reused after load.
`timescale 1ns/1ps
`default_nettype none
module pss_strap_src (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [7:0] cfg,
  input  wire logic       loaded,
  output logic      [7:0] pins
);
  logic flip_reg;
  logic flip_next;

  // Once loaded the pins serve other functions, so they toggle every cycle.
  always_comb begin
    flip_next = loaded ? ~flip_reg : 1'b0;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flip_reg <= 1'b0;
    end else begin
      flip_reg <= flip_next;
    end
  end

  assign pins = cfg ^ {8{flip_reg}};
endmodule
`default_nettype wire

/* testbench/tb.sv */
// Self-checking bench for the soft-strap default loader.
`timescale 1ns/1ps
`default_nettype none
module tb
  import pss_pkg::*;
;
  logic              clk;
  logic              rstn;
  logic [7:0]        cfg;
  logic [7:0]        pins;
  logic              ctl;
  logic              sa;
  logic              sm;
  logic [3:0]        wr;
  logic [2:0]        d_eee;
  logic [2:0]        d_bas;
  logic [1:0]        d_adv;
  logic [2:0]        d_mod;
  logic [11:0]       obs;
  logic [MODE_W-1:0] mode;
  logic              e0, e1, e2, ss, ng, sp, dp, fd, hd, xa, xm, dl;
  int                err_total;
  int                n_tests;
  int                cyc;

  pss_strap_src pss_strap_src_i (.clk(clk), .rstn(rstn), .cfg(cfg),
    .loaded(dl), .pins(pins));

  pss_top pss_top_i (.clk(clk), .rstn(rstn),
    .port1_energy_saving_strap(pins[0]), .fibre_mode_a(pins[1]),
    .auto_xover_strap(pins[2]), .manual_xover_strap(pins[3]),
    .negotiation_strap(pins[4]), .speed_strap(pins[5]),
    .duplex_strap(pins[6]), .fibre_mode_b(pins[7]),
    .crossover_control_field(ctl), .sw_xover_auto(sa), .sw_xover_mdix(sm),
    .sw_eee_wr(wr[3]), .sw_eee_data(d_eee), .sw_basic_wr(wr[2]),
    .sw_basic_data(d_bas), .sw_advert_wr(wr[1]), .sw_advert_data(d_adv),
    .sw_mode_wr(wr[0]), .sw_mode_data(d_mod),
    .phy_energy_saving_enable_bit(e0), .eee_cap_100tx(e1),
    .eee_adv_100tx(e2), .auto_crossover_strap_state_bit(ss),
    .negotiation_enable_bit(ng), .speed_select_low_bit(sp),
    .duplex_mode_bit(dp), .advert_10fd(fd), .advert_10hd(hd),
    .operating_mode(mode), .xover_auto_en(xa), .xover_mdix(xm),
    .defaults_loaded(dl));

  assign obs = {e0, e1, e2, ss, ng, sp, dp, fd, hd, mode};

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [11:0] exp_def(input logic [7:0] c);
    logic e, n, s, d;
    e = c[0] & ~c[1];
    n = c[4];
    s = c[5];
    d = c[6];
    if (c[7]) begin
      return {e, e, e, 1'b1, 1'b0, 1'b1, d, 2'h0, 1'b0, 1'b1, d};
    end
    return {e, e, e, c[2], n, n | s, n | d, (n | ~s) & d, n | ~s, n, s, d};
  endfunction

  function automatic logic [1:0] exp_x(input logic [7:0] c, input logic k,
                                       input logic a, input logic m);
    logic xa_e, xm_e;
    xa_e = k ? c[2] : a;
    xm_e = k ? c[3] : m;
    if (c[7]) begin
      return 2'h0;
    end
    return {xa_e, xm_e & ~xa_e};
  endfunction

  task automatic chk(input logic [11:0] seen, input logic [11:0] exp,
                     input string msg);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Reset, load with a write held across the load edge, then check.
  task automatic load(input logic [7:0] c);
    logic [11:0] ex;
    ex = exp_def(c);
    @(posedge clk);
    rstn <= 1'b0;
    cfg <= c;
    wr <= 4'h4;
    d_bas <= ~ex[7:5];
    @(posedge clk);
    #1 chk(obs, 12'h0, "outputs not clear in reset");
    chk({9'h0, dl, xa, xm}, 12'h0, "status not clear in reset");
    @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk({11'h0, dl}, 12'h0, "loaded too early");
    @(posedge clk);
    wr <= 4'h0;
    #1 chk({11'h0, dl}, 12'h1, "loaded late");
    chk({10'h0, xa, xm}, 12'h0, "crossover before run");
    chk(obs, ex, "defaults");
    @(posedge clk);
    #1 chk({10'h0, xa, xm}, {10'h0, exp_x(c, ctl, sa, sm)},
           "crossover");
    repeat (3) @(posedge clk);
    #1 chk(obs, ex, "changed after load");
  endtask

  task automatic sw(input logic [3:0] m, input logic [2:0] e,
                    input logic [2:0] b, input logic [1:0] a,
                    input logic [2:0] o);
    @(posedge clk);
    wr <= m;
    d_eee <= e;
    d_bas <= b;
    d_adv <= a;
    d_mod <= o;
  endtask

  initial begin
    rstn = 1'b0;
    cfg = 8'h00;
    ctl = 1'b1;
    sa = 1'b0;
    sm = 1'b0;
    wr = 4'h0;
    d_eee = 3'h0;
    d_bas = 3'h0;
    d_adv = 2'h0;
    d_mod = 3'h0;
    err_total = 0;
    n_tests = 0;
    repeat (12) @(posedge clk);
    load(8'h04);
    sw(4'hf, 3'h5, 3'h2, 2'h2, 3'h6);
    sw(4'h4, 3'h0, 3'h5, 2'h0, 3'h0);
    @(posedge clk);
    wr <= 4'h0;
    #1 chk(obs, 12'hbb6, "software writes");
    $display("test software writes done");
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      ctl <= 1'b0;
      sa <= k[1];
      sm <= k[0];
      @(posedge clk);
      #1 chk({10'h0, xa, xm}, {10'h0, exp_x(8'h04, 1'b0, k[1], k[0])},
             "sw crossover");
    end
    @(posedge clk);
    ctl <= 1'b1;
    $display("test software crossover done");
    for (int c = 0; c < 256; c++) begin
      load(c[7:0]);
    end
    $display("test strap sweep done");
    wrap_up();
  end

  initial begin
    cyc = 0;
    forever begin
      @(posedge clk);
      cyc++;
      if (cyc == 20000) begin
        err_total++;
        $display("[ERR] %0t run did not finish", $time);
        wrap_up();
      end
    end
  end
endmodule
`default_nettype wire
